// ===== inc/aepf_defines.svh
// Notes on behaviour
// R1: Field bits 5:4 pick each VA-hour source; code picks only phase B, A and C use own
// R2: Phase B voltage: B, A-C, -A-C, -A
// R3: Mode 01 puts A-C line rms in B
// R4: Software drops phase B from pulse outputs
// R5: Line mode copies accumulators after count
// R6: Bit 2 enables line-cycle apparent accumulation
// R7: Software keeps clear-on-read off in line mode
// R8: Bits 5:3 pick phases counted, any mix
// R9: Calibrate with one zero-crossing phase only
// R10: PF is abs(P)/S signed by reactive
// R11: Three signed 16-bit PF read registers
// R12: LSB 2^-15, 0x7FFF is 1, 0x8000 -1
// R13: Out of range PF saturates by sign
// R14: Default PF from instantaneous powers at 8kHz
// R15: Bit 7 selects line-cycle averaged PF
// R16: Software enables both line accumulations first
// R17: No-load forces PF to 1 or 0
// R18: Normal mode reads accumulator at access
// R19: Bit 6 clears VA-hour register after read
// R20: Enabled crossings count down, transfer, reload
`ifndef AEPF_DEFINES_SVH
`define AEPF_DEFINES_SVH

// Register indices; byte address is four times the index
`define AEPF_IDX_LINE_COUNT 16'hE60C
`define AEPF_IDX_LINE_MODE  16'hE702
`define AEPF_IDX_PF_A       16'hE902
`define AEPF_IDX_PF_B       16'hE903
`define AEPF_IDX_PF_C       16'hE904
`define AEPF_IDX_ACC_MODE   16'hE701
`define AEPF_IDX_VA_THRESH  16'hE700
`define AEPF_IDX_VAH_A      16'hE520
`define AEPF_IDX_VAH_B      16'hE521
`define AEPF_IDX_VAH_C      16'hE522
`define AEPF_IDX_VB_RMS     16'hE523

// Line-cycle mode field positions
`define AEPF_LM_ACTIVE_EN   0
`define AEPF_LM_APPARENT_EN 2
`define AEPF_LM_ZX_LO       3
`define AEPF_LM_ZX_HI       5
`define AEPF_LM_CLR_ON_READ 6
`define AEPF_LM_PF_AVG      7

// Accumulation mode field positions
`define AEPF_AM_SRC_LO 4
`define AEPF_AM_SRC_HI 5

// Reset values
`define AEPF_RST_LINE_COUNT 16'hFFFF
`define AEPF_RST_LINE_MODE  8'h78
`define AEPF_RST_ACC_MODE   8'h00
`define AEPF_RST_VA_THRESH  8'h03

// Power factor codes
`define AEPF_PF_POS_ONE 16'h7FFF
`define AEPF_PF_NEG_ONE 16'h8000
`define AEPF_PF_ZERO    16'h0000
`define AEPF_PF_ITER    4'hF

`endif

// ===== inc/aepf_pkg.sv
package aepf_pkg;

	// Phase B voltage source for apparent energy
	typedef enum logic [1:0] {
		AEPF_SRC_OWN      = 2'h0,
		AEPF_SRC_A_MIN_C  = 2'h1,
		AEPF_SRC_NA_MIN_C = 2'h2,
		AEPF_SRC_NEG_A    = 2'h3
	} aepf_src_e;

	// Divider sequencer, one-hot
	typedef enum logic [1:0] {
		AEPF_DIV_IDLE = 2'h1,
		AEPF_DIV_RUN  = 2'h2
	} aepf_div_state_e;

endpackage : aepf_pkg

// ===== inc/aepf_div_if.sv
`timescale 1ns/1ps
`default_nettype none

// Request and answer of one power factor division
interface aepf_div_if #(parameter int W = 40);
	logic         start; // One-cycle request
	logic [W-1:0] num;   // Absolute active value
	logic [W-1:0] den;   // Apparent value
	logic         neg;   // Result sign
	logic         done;  // One-cycle answer
	logic [15:0]  quo;   // Signed Q15 result

	modport req (output start, output num, output den, output neg,
		input done, input quo);
	modport div (input start, input num, input den, input neg,
		output done, output quo);
endinterface : aepf_div_if

`default_nettype wire

// ===== rtl/aepf_pf_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "aepf_defines.svh"

module aepf_pf_div #(
	parameter int W = 40
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Division request and answer
	aepf_div_if.div  dv
);

	aepf_pkg::aepf_div_state_e state, next_state; // Sequencer
	logic [W:0]   rem, next_rem;   // Partial remainder
	logic [W-1:0] den, next_den;   // Held divisor
	logic [14:0]  quo, next_quo;   // Fraction bits
	logic [3:0]   cnt, next_cnt;   // Bits left
	logic         neg, next_neg;   // Held sign
	logic         done, next_done; // Answer strobe
	logic [15:0]  res, next_res;   // Answer value

	assign dv.done = done;
	assign dv.quo  = res;

	// Restoring division, one fraction bit per cycle
	always_comb begin
		logic [W:0]  trial;
		logic [14:0] q;
		trial      = {rem[W-1:0], 1'b0};
		q          = quo;
		next_state = state;
		next_rem   = rem;
		next_den   = den;
		next_quo   = quo;
		next_cnt   = cnt;
		next_neg   = neg;
		next_done  = 1'b0;
		next_res   = res;
		unique case (state)
			aepf_pkg::AEPF_DIV_IDLE: begin
				if (dv.start) begin
					// Ratio at or past one, or no divisor: clamp by sign
					if (dv.den == '0 || dv.num >= dv.den) begin
						next_res  = dv.neg ? `AEPF_PF_NEG_ONE : `AEPF_PF_POS_ONE; // [R13] [R12]
						next_done = 1'b1;
					end else begin
						next_rem   = {1'b0, dv.num};
						next_den   = dv.den;
						next_quo   = '0;
						next_cnt   = `AEPF_PF_ITER;
						next_neg   = dv.neg;
						next_state = aepf_pkg::AEPF_DIV_RUN;
					end
				end
			end
			aepf_pkg::AEPF_DIV_RUN: begin
				// Remainder stays below divisor, so trial fits W+1 bits
				if (trial >= {1'b0, den}) begin
					next_rem = trial - {1'b0, den};
					q        = {quo[13:0], 1'b1};
				end else begin
					next_rem = trial;
					q        = {quo[13:0], 1'b0};
				end
				next_quo = q;
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					// Magnitude over S, signed two's complement
					next_res   = neg ? 16'(-{1'b0, q}) : {1'b0, q}; // [R10] [R12]
					next_done  = 1'b1;
					next_state = aepf_pkg::AEPF_DIV_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= aepf_pkg::AEPF_DIV_IDLE;
			rem   <= '0;
			den   <= '0;
			quo   <= '0;
			cnt   <= 4'h0;
			neg   <= 1'b0;
			done  <= 1'b0;
			res   <= `AEPF_PF_ZERO;
		end else begin
			state <= next_state;
			rem   <= next_rem;
			den   <= next_den;
			quo   <= next_quo;
			cnt   <= next_cnt;
			neg   <= next_neg;
			done  <= next_done;
			res   <= next_res;
		end
	end

endmodule : aepf_pf_div

`default_nettype wire

// ===== rtl/aepf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aepf_defines.svh"

module aepf_top #(
	parameter int PW = 24, // Sample width
	parameter int EW = 40  // Line-cycle power sum width
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [17:0]          wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// DSP timing strobes
	input  wire logic                 dsp_tick,
	input  wire logic                 acc_tick,
	// Instantaneous phase voltages
	input  wire logic signed [PW-1:0] v_inst_a,
	input  wire logic signed [PW-1:0] v_inst_b,
	input  wire logic signed [PW-1:0] v_inst_c,
	// Rms values, phase B voltage rms taken from vb_derived
	input  wire logic [PW-1:0]        vrms_a,
	input  wire logic [PW-1:0]        vrms_b,
	input  wire logic [PW-1:0]        vrms_c,
	input  wire logic [PW-1:0]        irms_a,
	input  wire logic [PW-1:0]        irms_b,
	input  wire logic [PW-1:0]        irms_c,
	// Total active and fundamental reactive powers
	input  wire logic signed [PW-1:0] watt_a,
	input  wire logic signed [PW-1:0] watt_b,
	input  wire logic signed [PW-1:0] watt_c,
	input  wire logic signed [PW-1:0] fvar_a,
	input  wire logic signed [PW-1:0] fvar_b,
	input  wire logic signed [PW-1:0] fvar_c,
	// Zero crossings and no-load flags, bit 0 is phase A
	input  wire logic [2:0]           zero_cross,
	input  wire logic                 noload_en,
	input  wire logic [2:0]           va_noload,
	input  wire logic [2:0]           var_noload,
	input  wire logic [2:0]           wva_noload,
	// Derived phase B voltage and line period strobe
	output logic signed [PW:0]        vb_derived,
	output logic                      line_cycle_end
);

	// Per-phase views of the inputs
	logic [PW-1:0]        vrms [3];
	logic [PW-1:0]        irms [3];
	logic signed [PW-1:0] watt [3];
	logic signed [PW-1:0] fvar [3];
	assign vrms = '{vrms_a, vrms_b, vrms_c};
	assign irms = '{irms_a, irms_b, irms_c};
	assign watt = '{watt_a, watt_b, watt_c};
	assign fvar = '{fvar_a, fvar_b, fvar_c};

	// Control registers
	logic [15:0] line_count, next_line_count;  // Half line cycles
	logic [7:0]  line_mode, next_line_mode;    // Line-cycle mode
	logic [7:0]  acc_mode, next_acc_mode;      // Accumulation mode
	logic [7:0]  va_thresh, next_va_thresh;    // First stage threshold
	logic [PW-1:0] vb_rms, next_vb_rms;        // Phase B voltage rms

	// Field views
	logic       line_active_enable;
	logic       line_apparent_enable;
	logic [2:0] zero_cross_phase_select;
	logic       clear_on_read_enable;
	logic       averaged_pf_select;
	assign line_active_enable      = line_mode[`AEPF_LM_ACTIVE_EN];
	assign line_apparent_enable    = line_mode[`AEPF_LM_APPARENT_EN];
	assign zero_cross_phase_select = line_mode[`AEPF_LM_ZX_HI:`AEPF_LM_ZX_LO];
	assign clear_on_read_enable    = line_mode[`AEPF_LM_CLR_ON_READ];
	assign averaged_pf_select      = line_mode[`AEPF_LM_PF_AVG];

	// Bus decode
	logic        req;  // New request this cycle
	logic        wr;   // Write taken this cycle
	logic [15:0] idx;  // Register index
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = req && wb_we_i;
	assign idx = wb_adr_i[17:2];

	// Per-phase results read by the bus
	logic [15:0] pf_q [3];     // Power factor registers
	logic [31:0] vah_view [3]; // VA-hour as software sees it
	logic [2:0]  rd_clear;     // Clear-on-read strike

	// Half-cycle counter
	logic [15:0] lcnt, next_lcnt;
	logic        line_end, next_line_end;

	// Control register writes with byte lanes
	always_comb begin
		next_line_count = line_count;
		next_line_mode  = line_mode;
		next_acc_mode   = acc_mode;
		next_va_thresh  = va_thresh;
		next_vb_rms     = dsp_tick ? vrms[1] : vb_rms; // [R3]
		if (wr) begin
			unique case (idx)
				`AEPF_IDX_LINE_COUNT: begin
					if (wb_sel_i[0]) next_line_count[7:0]  = wb_dat_i[7:0];
					if (wb_sel_i[1]) next_line_count[15:8] = wb_dat_i[15:8];
				end
				`AEPF_IDX_LINE_MODE: begin
					if (wb_sel_i[0]) next_line_mode = wb_dat_i[7:0];
				end
				`AEPF_IDX_ACC_MODE: begin
					if (wb_sel_i[0]) next_acc_mode = wb_dat_i[7:0];
				end
				`AEPF_IDX_VA_THRESH: begin
					if (wb_sel_i[0]) next_va_thresh = wb_dat_i[7:0];
				end
				default: begin
					// Read-only or unmapped: write ignored
				end
			endcase
		end
	end

	// Control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			line_count <= `AEPF_RST_LINE_COUNT;
			line_mode  <= `AEPF_RST_LINE_MODE;
			acc_mode   <= `AEPF_RST_ACC_MODE;
			va_thresh  <= `AEPF_RST_VA_THRESH;
			vb_rms     <= '0;
		end else begin
			line_count <= next_line_count;
			line_mode  <= next_line_mode;
			acc_mode   <= next_acc_mode;
			va_thresh  <= next_va_thresh;
			vb_rms     <= next_vb_rms;
		end
	end

	// Phase B voltage feeding its rms and apparent power
	logic signed [PW:0] next_vb_derived;
	always_comb begin
		logic signed [PW:0] a;
		logic signed [PW:0] b;
		logic signed [PW:0] c;
		a = {v_inst_a[PW-1], v_inst_a};
		b = {v_inst_b[PW-1], v_inst_b};
		c = {v_inst_c[PW-1], v_inst_c};
		// One bit of headroom keeps A-C from wrapping
		unique case (aepf_pkg::aepf_src_e'(acc_mode[`AEPF_AM_SRC_HI:`AEPF_AM_SRC_LO])) // [R1]
			aepf_pkg::AEPF_SRC_OWN:      next_vb_derived = b;      // [R2]
			aepf_pkg::AEPF_SRC_A_MIN_C:  next_vb_derived = a - c;  // [R2] [R3]
			aepf_pkg::AEPF_SRC_NA_MIN_C: next_vb_derived = -a - c; // [R2]
			aepf_pkg::AEPF_SRC_NEG_A:    next_vb_derived = -a;     // [R2]
		endcase
	end

	// Derived voltage register
	always_ff @(posedge clk) begin
		if (rst) vb_derived <= '0;
		else     vb_derived <= next_vb_derived;
	end

	// Count enabled crossings down, reload at the end of a period
	always_comb begin
		next_lcnt     = lcnt;
		next_line_end = 1'b0;
		if (wr && idx == `AEPF_IDX_LINE_COUNT) begin
			next_lcnt = next_line_count;
		end else if (|(zero_cross & zero_cross_phase_select)) begin // [R8]
			if (lcnt <= 16'h0001) begin
				next_lcnt     = line_count; // [R20]
				next_line_end = 1'b1;
			end else begin
				next_lcnt = lcnt - 16'h0001; // [R20]
			end
		end
	end

	// Counter registers; the end pulse also leaves as an output
	always_ff @(posedge clk) begin
		if (rst) begin
			lcnt           <= `AEPF_RST_LINE_COUNT;
			line_end       <= 1'b0;
			line_cycle_end <= 1'b0;
		end else begin
			lcnt           <= next_lcnt;
			line_end       <= next_line_end;
			line_cycle_end <= next_line_end;
		end
	end

	// Per-phase energy and power factor
	for (genvar i = 0; i < 3; i++) begin : g_ph
		logic [2*PW-1:0]      prod;                 // Vrms times Irms
		logic [PW-1:0]        s_inst;               // Apparent power
		logic [35:0]          st1, next_st1;        // First stage
		logic [31:0]          acc, next_acc;        // Internal accumulator
		logic [31:0]          vah, next_vah;        // Line-mode VA-hours
		logic signed [EW-1:0] psum, next_psum;      // Active sum
		logic [EW-1:0]        ssum, next_ssum;      // Apparent sum
		logic [15:0]          pf, next_pf;          // Power factor
		logic                 pulse;                // Threshold crossed
		aepf_div_if #(.W(EW)) dv ();

		assign prod   = vrms[i] * irms[i]; // [R1]
		assign s_inst = prod[2*PW-1:PW];
		assign pf_q[i] = pf;
		// Outside line mode the accumulator is read directly
		assign vah_view[i] = line_apparent_enable ? vah : acc; // [R5] [R18]
		// Clearing is not offered while line mode owns the registers
		assign rd_clear[i] = req && !wb_we_i && clear_on_read_enable
			&& !line_apparent_enable
			&& idx == 16'(`AEPF_IDX_VAH_A + i); // [R19]

		// Two-stage apparent energy integration
		always_comb begin
			logic [35:0] sum;
			logic [35:0] thr;
			thr      = {1'b0, va_thresh, 27'h0};
			sum      = st1 + 36'(s_inst);
			next_st1 = st1;
			pulse    = 1'b0;
			if (acc_tick) begin
				// A zero threshold would pulse forever, so it stalls
				if (thr != '0 && sum >= thr) begin
					next_st1 = sum - thr;
					pulse    = 1'b1;
				end else begin
					next_st1 = sum;
				end
			end
			next_vah = vah;
			next_acc = acc;
			if (line_end && line_apparent_enable) begin
				next_vah = acc + 32'(pulse); // [R5] [R6] [R20]
				next_acc = 32'(pulse);       // [R20]
			end else if (rd_clear[i]) begin
				next_acc = 32'(pulse); // [R19]
			end else begin
				next_acc = acc + 32'(pulse);
			end
			// Line sums feed the averaged power factor
			next_psum = line_end ? '0 : psum;
			next_ssum = line_end ? '0 : ssum;
			if (dsp_tick && line_active_enable && !line_end)
				next_psum = psum + EW'(watt[i]);
			if (dsp_tick && line_apparent_enable && !line_end)
				next_ssum = ssum + EW'(s_inst);
		end

		// Division request, instantaneous or line averaged
		always_comb begin
			logic signed [EW-1:0] p;
			p = averaged_pf_select ? psum : EW'(watt[i]);
			dv.start = averaged_pf_select ? line_end : dsp_tick; // [R14] [R15]
			dv.num   = p[EW-1] ? EW'(-p) : EW'(p);             // [R10]
			dv.den   = averaged_pf_select ? ssum : EW'(s_inst);
			// Reactive sign, or active sign when reactive is idle
			dv.neg   = var_noload[i] ? watt[i][PW-1] : fvar[i][PW-1]; // [R10] [R13]
			next_pf  = pf;
			if (dv.done) begin
				if (noload_en && va_noload[i])
					next_pf = `AEPF_PF_POS_ONE; // [R17]
				else if (noload_en && wva_noload[i])
					next_pf = `AEPF_PF_ZERO;    // [R17]
				else
					next_pf = dv.quo;           // [R11]
			end
		end

		aepf_pf_div #(.W(EW)) u_div (
			.clk (clk),
			.rst (rst),
			.dv  (dv.div)
		);

		// Per-phase registers
		always_ff @(posedge clk) begin
			if (rst) begin
				st1  <= '0;
				acc  <= '0;
				vah  <= '0;
				psum <= '0;
				ssum <= '0;
				pf   <= `AEPF_PF_ZERO;
			end else begin
				st1  <= next_st1;
				acc  <= next_acc;
				vah  <= next_vah;
				psum <= next_psum;
				ssum <= next_ssum;
				pf   <= next_pf;
			end
		end
	end

	// Read data and a one-cycle ack for every request
	logic [31:0] next_dat;
	always_comb begin
		next_dat = wb_dat_o;
		if (req) begin
			unique case (idx)
				`AEPF_IDX_LINE_COUNT: next_dat = {16'h0000, line_count};
				`AEPF_IDX_LINE_MODE:  next_dat = {24'h000000, line_mode};
				`AEPF_IDX_ACC_MODE:   next_dat = {24'h000000, acc_mode};
				`AEPF_IDX_VA_THRESH:  next_dat = {24'h000000, va_thresh};
				`AEPF_IDX_PF_A:       next_dat = {16'h0000, pf_q[0]}; // [R11]
				`AEPF_IDX_PF_B:       next_dat = {16'h0000, pf_q[1]}; // [R11]
				`AEPF_IDX_PF_C:       next_dat = {16'h0000, pf_q[2]}; // [R11]
				`AEPF_IDX_VAH_A:      next_dat = vah_view[0];        // [R18]
				`AEPF_IDX_VAH_B:      next_dat = vah_view[1];        // [R18]
				`AEPF_IDX_VAH_C:      next_dat = vah_view[2];        // [R18]
				`AEPF_IDX_VB_RMS:     next_dat = 32'(vb_rms);        // [R3]
				default:              next_dat = 32'h00000000;
			endcase
		end
	end

	// Bus answer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= next_dat;
		end
	end

endmodule : aepf_top

`default_nettype wire

// ===== dv/aepf_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "aepf_defines.svh"

module aepf_top_sva #(
	parameter int PW = 24 // Sample width
) (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// Register bus
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [17:0]          wb_adr_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	// Voltages and line period
	input wire logic signed [PW-1:0] v_inst_a,
	input wire logic signed [PW-1:0] v_inst_b,
	input wire logic signed [PW-1:0] v_inst_c,
	input wire logic [2:0]           zero_cross,
	input wire logic signed [PW:0]   vb_derived,
	input wire logic                 line_cycle_end
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic        take;          // Request taken at this edge
	logic [15:0] ix;            // Word index
	logic        rd_cnt;        // Line count read taken
	logic        rd_lm;         // Line mode read taken
	logic        rd_am;         // Accumulation mode read taken
	logic        rd_un;         // Unmapped read taken
	logic        zx_sel;        // Selected crossing present
	logic [1:0]  src;           // Source field copy
	logic [15:0] cnt, next_cnt; // Line count copy
	logic [7:0]  lm, next_lm;   // Line mode copy
	logic [7:0]  am, next_am;   // Accumulation mode copy

	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !rst;
	assign ix = wb_adr_i[17:2];
	assign rd_cnt = take && !wb_we_i && ix == `AEPF_IDX_LINE_COUNT;
	assign rd_lm = take && !wb_we_i && ix == `AEPF_IDX_LINE_MODE;
	assign rd_am = take && !wb_we_i && ix == `AEPF_IDX_ACC_MODE;
	assign rd_un = take && !wb_we_i && !(ix inside {`AEPF_IDX_LINE_COUNT, `AEPF_IDX_LINE_MODE,
		`AEPF_IDX_PF_A, `AEPF_IDX_PF_B, `AEPF_IDX_PF_C, `AEPF_IDX_ACC_MODE, `AEPF_IDX_VA_THRESH,
		`AEPF_IDX_VAH_A, `AEPF_IDX_VAH_B, `AEPF_IDX_VAH_C, `AEPF_IDX_VB_RMS});
	assign zx_sel = |(zero_cross & lm[5:3]);
	assign src = am[5:4];

	// Copies follow taken writes; byte lanes ignored, so only full-lane writes are modelled
	always_comb begin
		next_cnt = cnt;
		next_lm = lm;
		next_am = am;
		if (take && wb_we_i) begin
			if (ix == `AEPF_IDX_LINE_COUNT) next_cnt = wb_dat_i[15:0];
			if (ix == `AEPF_IDX_LINE_MODE) next_lm = wb_dat_i[7:0];
			if (ix == `AEPF_IDX_ACC_MODE) next_am = wb_dat_i[7:0];
		end
	end

	// Copy registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= `AEPF_RST_LINE_COUNT;
			lm <= `AEPF_RST_LINE_MODE;
			am <= `AEPF_RST_ACC_MODE;
		end else begin
			cnt <= next_cnt;
			lm <= next_lm;
			am <= next_am;
		end
	end

	// Expected phase B voltage for a source code
	function automatic logic signed [PW:0] vb_f(input logic [1:0] s,
		input logic signed [PW-1:0] a, b, c);
		case (s)
			2'h0: return b;
			2'h1: return a - c;
			2'h2: return -a - c;
			default: return -a;
		endcase
	endfunction : vb_f

	AST_ACK_NEXT: assert property (take |=> wb_ack_o)
		else $error("no ack one cycle after a request");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
		else $error("ack without a request");
	AST_RST_QUIET: assert property ($past(rst) |-> !wb_ack_o && !line_cycle_end && vb_derived == '0)
		else $error("outputs active just after reset");
	AST_VB_SRC: assert property (!$past(rst) |-> vb_derived ==
		vb_f($past(src), $past(v_inst_a), $past(v_inst_b), $past(v_inst_c)))
		else $error("derived phase B voltage wrong");
	AST_RD_CNT: assert property ($past(rd_cnt) |-> wb_dat_o == {16'h0000, $past(cnt)})
		else $error("line count read wrong");
	AST_RD_LM: assert property ($past(rd_lm) |-> wb_dat_o == {24'h000000, $past(lm)})
		else $error("line mode read wrong");
	AST_RD_AM: assert property ($past(rd_am) |-> wb_dat_o == {24'h000000, $past(am)})
		else $error("accumulation mode read wrong");
	AST_RD_UN: assert property ($past(rd_un) |-> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	AST_LCE_ZX: assert property (line_cycle_end |-> $past(zx_sel))
		else $error("line end without a selected crossing");

	// Main scenarios reached
	cover property (rd_un ##1 wb_ack_o);
	cover property (line_cycle_end);
	cover property (src == 2'h3);
endmodule : aepf_top_sva

bind aepf_top aepf_top_sva #(.PW(PW)) u_sva (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .v_inst_a, .v_inst_b, .v_inst_c,
	.zero_cross, .vb_derived, .line_cycle_end);

`default_nettype wire

// ===== dv/aepf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "aepf_defines.svh"

// Compare, count and report
`define AEPF_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module aepf_top_tb;
	logic              clk = 1'h0, rst = 1'h1;
	logic              wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
	logic [3:0]        wb_sel_i = 4'hF;
	logic [17:0]       wb_adr_i = 18'h00000;
	logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, rdata;
	logic              dsp_tick = 1'h0, acc_tick = 1'h0, noload_en = 1'h0, line_cycle_end;
	logic signed [23:0] v_inst_a = 24'h000100, v_inst_b = 24'h000020, v_inst_c = 24'h000030;
	logic [23:0]       vrms_a = 24'h800000, vrms_b = 24'h800000, vrms_c = 24'h400000;
	logic [23:0]       irms_a = 24'h800000, irms_b = 24'h400000, irms_c = 24'h400000;
	logic signed [23:0] watt_a = 24'h0, watt_b = 24'h0, watt_c = 24'h0;
	logic signed [23:0] fvar_a = 24'h0, fvar_b = 24'h0, fvar_c = 24'h0;
	logic [2:0]        zero_cross = 3'h0, va_noload = 3'h0, var_noload = 3'h0, wva_noload = 3'h0;
	logic signed [24:0] vb_derived;
	int                fail_count = 0, total_checks = 0, lce_n = 0;
	// Reset table and derived voltages for a=0x100, b=0x20, c=0x30
	logic [15:0] rix [10] = '{`AEPF_IDX_LINE_COUNT, `AEPF_IDX_LINE_MODE, `AEPF_IDX_ACC_MODE,
		`AEPF_IDX_VA_THRESH, `AEPF_IDX_PF_A, `AEPF_IDX_PF_B, `AEPF_IDX_PF_C,
		`AEPF_IDX_VAH_A, `AEPF_IDX_VAH_B, `AEPF_IDX_VAH_C};
	logic [31:0] rva [10] = '{32'hFFFF, 32'h78, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0};
	logic [24:0] vbx [4] = '{25'h0000020, 25'h00000D0, 25'h1FFFED0, 25'h1FFFF00};

	aepf_top dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .dsp_tick, .acc_tick, .v_inst_a, .v_inst_b, .v_inst_c,
		.vrms_a, .vrms_b, .vrms_c, .irms_a, .irms_b, .irms_c, .watt_a, .watt_b, .watt_c,
		.fvar_a, .fvar_b, .fvar_c, .zero_cross, .noload_en, .va_noload, .var_noload,
		.wva_noload, .vb_derived, .line_cycle_end);

	always #2.5 clk = ~clk;
	// Count line period pulses
	always @(posedge clk) if (line_cycle_end === 1'h1) lce_n++;

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	// One classic cycle, held until ack is sampled; bounded wait
	task automatic wb(input logic we, input logic [15:0] ix, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= {ix, 2'h0};
		wb_dat_i <= d;
		@(posedge clk);
		while (wb_ack_o !== 1'h1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		rdata = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		if (n == 16) begin
			fail_count++;
			summarize();
		end
		@(posedge clk);
	endtask : wb

	task automatic wr(input logic [15:0] ix, input logic [31:0] d);
		wb(1'h1, ix, d);
	endtask : wr

	task automatic chk_rd(input logic [15:0] ix, input logic [31:0] e);
		wb(1'h0, ix, 32'h0);
		`AEPF_CHK(rdata, e)
	endtask : chk_rd

	// Energy strobes every other cycle
	task automatic acc_pulses(input int n);
		repeat (n) begin
			acc_tick <= 1'h1;
			@(posedge clk);
			acc_tick <= 1'h0;
			@(posedge clk);
		end
	endtask : acc_pulses

	// Crossing pulse; settle past the registered line end
	task automatic zx(input logic [2:0] m);
		zero_cross <= m;
		@(posedge clk);
		zero_cross <= 3'h0;
		repeat (3) @(posedge clk);
	endtask : zx

	task automatic set_in(input logic [23:0] w, f, input logic [2:0] vn, an, wn);
		{watt_a, watt_b, watt_c} <= {3{w}};
		{fvar_a, fvar_b, fvar_c} <= {3{f}};
		var_noload <= vn;
		va_noload <= an;
		wva_noload <= wn;
		noload_en <= |{an, wn};
		@(posedge clk);
	endtask : set_in

	// Sample strobe, then wait out the divider
	task automatic dsp;
		dsp_tick <= 1'h1;
		@(posedge clk);
		dsp_tick <= 1'h0;
		repeat (24) @(posedge clk);
	endtask : dsp

	task automatic pf_chk(input logic [47:0] e);
		chk_rd(`AEPF_IDX_PF_A, {16'h0, e[47:32]});
		chk_rd(`AEPF_IDX_PF_B, {16'h0, e[31:16]});
		chk_rd(`AEPF_IDX_PF_C, {16'h0, e[15:0]});
	endtask : pf_chk

	task automatic pf_case(input logic [23:0] w, f, input logic [2:0] vn, an, wn,
		input logic [47:0] e);
		set_in(w, f, vn, an, wn);
		dsp();
		pf_chk(e);
	endtask : pf_case

	// Main sequence; apparent powers are A 0x400000, B 0x200000, C 0x100000
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 10; i++) chk_rd(rix[i], rva[i]);
		wr(`AEPF_IDX_PF_A, 32'h1234);
		chk_rd(`AEPF_IDX_PF_A, 32'h0);
		chk_rd(16'h0123, 32'h0);
		wr(`AEPF_IDX_LINE_COUNT, 32'hABCD);
		chk_rd(`AEPF_IDX_LINE_COUNT, 32'hABCD);
		// Every source code; no pulse outputs here, so no phase B term to mask
		for (int s = 0; s < 4; s++) begin
			wr(`AEPF_IDX_ACC_MODE, 32'(s) << 4);
			chk_rd(`AEPF_IDX_ACC_MODE, 32'(s) << 4);
			`AEPF_CHK(vb_derived, vbx[s])
		end
		dsp(); // Rms copy only moves on a sample strobe
		chk_rd(`AEPF_IDX_VB_RMS, {8'h0, vrms_b});
		pf_case(24'h080000, 24'h000001, 3'h0, 3'h0, 3'h0, 48'h100020004000);
		pf_case(24'hF80000, 24'hFFFFFF, 3'h0, 3'h0, 3'h0, 48'hF000E000C000);
		pf_case(24'h080000, 24'hFFFFFF, 3'h7, 3'h0, 3'h0, 48'h100020004000);
		pf_case(24'h600000, 24'h000001, 3'h0, 3'h0, 3'h0, 48'h7FFF7FFF7FFF);
		pf_case(24'h600000, 24'hFFFFFF, 3'h0, 3'h0, 3'h0, 48'h800080008000);
		pf_case(24'h080000, 24'hFFFFFF, 3'h0, 3'h7, 3'h0, 48'h7FFF7FFF7FFF);
		pf_case(24'h080000, 24'h000001, 3'h0, 3'h0, 3'h7, 48'h000000000000);
		// Energy read at access, then clear on read
		wr(`AEPF_IDX_VA_THRESH, 32'h1);
		wr(`AEPF_IDX_LINE_MODE, 32'h38);
		acc_pulses(128);
		chk_rd(`AEPF_IDX_VAH_A, 32'h4);
		chk_rd(`AEPF_IDX_VAH_B, 32'h2);
		chk_rd(`AEPF_IDX_VAH_C, 32'h1);
		chk_rd(`AEPF_IDX_VAH_A, 32'h4);
		wr(`AEPF_IDX_LINE_MODE, 32'h78);
		chk_rd(`AEPF_IDX_VAH_A, 32'h4);
		chk_rd(`AEPF_IDX_VAH_A, 32'h0);
		// Line mode on phase A crossings, clear on read off
		wr(`AEPF_IDX_LINE_MODE, 32'h0C);
		wr(`AEPF_IDX_LINE_COUNT, 32'h2);
		acc_pulses(32);
		zx(3'h6);
		zx(3'h6);
		`AEPF_CHK(lce_n, 0)
		zx(3'h1);
		`AEPF_CHK(lce_n, 0)
		zx(3'h1);
		`AEPF_CHK(lce_n, 1)
		chk_rd(`AEPF_IDX_VAH_A, 32'h1);
		acc_pulses(64);
		chk_rd(`AEPF_IDX_VAH_A, 32'h1);
		zx(3'h1);
		zx(3'h1);
		chk_rd(`AEPF_IDX_VAH_A, 32'h2);
		wr(`AEPF_IDX_LINE_MODE, 32'h3C);
		zx(3'h5);
		`AEPF_CHK(lce_n, 2)
		zx(3'h2);
		`AEPF_CHK(lce_n, 3)
		// Averaged factor moves only at line end
		set_in(24'h080000, 24'h000001, 3'h0, 3'h0, 3'h0);
		wr(`AEPF_IDX_LINE_MODE, 32'hBD);
		repeat (4) dsp();
		chk_rd(`AEPF_IDX_PF_A, 32'h0);
		zx(3'h1);
		zx(3'h1);
		repeat (24) @(posedge clk);
		pf_chk(48'h100020004000);
		summarize();
	end
endmodule : aepf_top_tb

`default_nettype wire
